// file: src/fpc_link_if.sv
// Purpose: join between the synthesiser and the user logic that drives it
// Assumes: both ends clocked by the same mclk
// Notes: configuration port follows classic single-cycle handshake signalling
`default_nettype none
interface fpc_link_if;
  logic wb_cyc;
  logic wb_stb;
  logic wb_we;
  logic [3:0] wb_adr;
  logic [7:0] wb_dat_w;
  logic [7:0] wb_dat_r;
  logic wb_ack;
  logic [1:0] phase_target_select;
  logic phase_shift_direction;
  logic phase_shift_pulse;
  logic reference_source_switch;
  logic lock;

  modport dev (
    input wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w,
    output wb_dat_r, wb_ack,
    input phase_target_select, phase_shift_direction, phase_shift_pulse,
    input reference_source_switch,
    output lock
  );
  modport usr (
    output wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w,
    input wb_dat_r, wb_ack,
    output phase_target_select, phase_shift_direction, phase_shift_pulse,
    output reference_source_switch,
    input lock
  );
endinterface
`default_nettype wire

// file: src/fpc_pkg.sv
// Purpose: shared constants for the fractional clock synthesiser and its user end
// Assumes: one 10 MHz system clock on both ends
// Notes: configuration registers are byte wide behind a small word-addressed port
`default_nettype none
package fpc_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 10000;
  localparam int ACQ_TIME_NS = 50000;
  localparam int ACQ_CYCLES = (ACQ_TIME_NS * CLK_KHZ + 999999) / 1000000;
  localparam logic [15:0] ACQ_CNT = 16'(ACQ_CYCLES);
  localparam int FB_TIMEOUT_US_DEF = 1000;

  // ----------------------------------------------------------------
  // widths and limits
  // ----------------------------------------------------------------
  localparam int ADR_W = 4;
  localparam int DAT_W = 8;
  localparam int CH_N = 4;
  localparam logic [7:0] DIV_MIN = 8'h01;
  localparam logic [7:0] DIV_MAX = 8'h80;
  localparam logic [7:0] MULT_MIN = 8'h01;
  localparam logic [1:0] SEL_TO_CH = 2'h1;
  localparam logic [1:0] CH_PRIMARY = 2'h0;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] A_MULT = 4'h0;
  localparam logic [3:0] A_FRAC_LO = 4'h1;
  localparam logic [3:0] A_FRAC_HI = 4'h2;
  localparam logic [3:0] A_CASCADE = 4'h3;
  localparam logic [3:0] A_DIV0 = 4'h4;
  localparam logic [3:0] A_DIV3 = 4'h7;
  localparam logic [3:0] A_PH1 = 4'h8;
  localparam logic [3:0] A_PH3 = 4'hA;
  localparam logic [3:0] A_CTRL = 4'hB;
  localparam logic [3:0] A_STATUS = 4'hC;
  localparam int B_FB_EXT = 0;
  localparam int B_LOCK = 0;
  localparam int B_REF_SEL = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] R_MULT = 8'h04;
  localparam logic [15:0] R_FRAC = 16'h0000;
  localparam logic [7:0] R_DIV = 8'h04;
  localparam logic [7:0] R_PHASE = 8'h00;

  typedef enum {FPC_IDLE, FPC_BUS} fpc_host_st_type;

  // out-of-range divider values are pulled into 1..128
  function automatic logic [7:0] fpc_div_clamp(input logic [7:0] v);
    if (v < DIV_MIN) begin
      return DIV_MIN;
    end
    if (v > DIV_MAX) begin
      return DIV_MAX;
    end
    return v;
  endfunction
endpackage
`default_nettype wire

// file: src/fpc_synth_end.sv
// Purpose: behavioural fractional-N clock synthesiser with four divided outputs
// Assumes: reference and feedback pins are well below mclk/2
// Notes: the oscillator is a credit counter fed by reference edges
// Behaviour
// - reference from pin or routing; feedback likewise
// - feedback multiplier raises output above reference
// - 16-bit fractional multiplication of the reference
// - every output has its own divider
// - divider values 1 through 128 accepted
// - dividers can cascade for very slow clocks
// - all four outputs usable as global clocks
// - lock indicator set on lock, cleared on loss
// - secondary outputs get programmable phase offset
// - offset from static setting or dynamic port
// - feedback phase step may drop lock; wait
// - user selects target output with two bits
// - user sets step direction advance or delay
// - each pulse toggle moves one step
// - reference switchable between two sources live
// - configuration port rewrites settings while running
// - after rewrite wait acquisition time and lock
`default_nettype none
module fpc_synth_end #(
  parameter int FB_TIMEOUT_US = fpc_pkg::FB_TIMEOUT_US_DEF
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic reference_clock_in,
  input wire logic reference_clock_alt,
  input wire logic feedback_clock_in,
  output logic primary_clock_out,
  output logic first_aux_clock_out,
  output logic second_aux_clock_out,
  output logic third_aux_clock_out,
  fpc_link_if.dev link
);
  localparam logic [15:0] FB_TMO = 16'(FB_TIMEOUT_US * fpc_pkg::CLK_KHZ / 1000);

  typedef struct packed {
    logic [1:0] refa_sy;
    logic [1:0] refb_sy;
    logic [1:0] fb_sy;
    logic ref_prev;
    logic fb_prev;
    logic step_prev;
    logic ref_sel;
    logic [7:0] mult;
    logic [15:0] frac;
    logic [15:0] acc;
    logic [9:0] credit;
    logic [3:0][7:0] div;
    logic [3:0][7:0] cnt;
    logic [3:0] clk_o;
    logic [3:0] cascade;
    logic [3:0] adv;
    logic [3:0] dly;
    logic [2:0][7:0] phase;
    logic fb_ext;
    logic lock;
    logic ack;
    logic [7:0] rdata;
    logic [15:0] acq;
    logic [15:0] watch;
  } fpc_dev_type;

  fpc_dev_type r;
  fpc_dev_type n;
  logic ref_lvl;
  logic ref_edge;
  logic fb_lvl;
  logic fb_edge;
  logic vtick;
  logic take;
  logic upset;
  logic lost;
  logic step_edge;
  logic [1:0] tgt;
  logic [3:0] otick;
  logic [3:0] tin;
  logic [16:0] sum;
  logic [10:0] cr;
  logic [7:0] pv;

  // ----------------------------------------------------------------
  // pins, oscillator and configuration port
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    otick = '0;
    tin = '0;
    pv = 8'h00;
    // pins are asynchronous to mclk: two flops before any use
    n.refa_sy = {r.refa_sy[0], reference_clock_in};
    n.refb_sy = {r.refb_sy[0], reference_clock_alt};
    n.fb_sy = {r.fb_sy[0], feedback_clock_in};
    n.ref_sel = link.reference_source_switch;
    ref_lvl = r.ref_sel ? r.refb_sy[1] : r.refa_sy[1];
    ref_edge = ref_lvl & ~r.ref_prev;
    n.ref_prev = ref_lvl;
    // feedback from the external pin or the primary output
    fb_lvl = r.fb_ext ? r.fb_sy[1] : r.clk_o[fpc_pkg::CH_PRIMARY];
    fb_edge = fb_lvl & ~r.fb_prev;
    n.fb_prev = fb_lvl;

    // each reference edge grants mult.frac oscillator ticks
    sum = {1'b0, r.acc} + {1'b0, r.frac};
    vtick = (r.credit != 10'h000);
    cr = {1'b0, r.credit} - {10'h000, vtick};
    if (ref_edge) begin
      n.acc = sum[15:0];
      cr = cr + {3'h0, r.mult} + {10'h000, sum[16]};
    end
    // saturate rather than wrap when the reference outruns mclk
    n.credit = cr[10] ? 10'h3FF : cr[9:0];

    // dividers: each counts oscillator ticks or its neighbour's toggles
    for (int i = 0; i < fpc_pkg::CH_N; i++) begin
      if (i != 0 && r.cascade[i]) begin
        tin[i] = otick[(i == 0) ? 0 : i - 1];
      end else begin
        tin[i] = vtick;
      end
      if (r.dly[i] && tin[i]) begin
        n.dly[i] = 1'b0; // swallow one tick: delay by one step
      end else if (tin[i] || r.adv[i]) begin
        if (r.adv[i] && !tin[i]) begin
          n.adv[i] = 1'b0; // extra tick: advance by one step
        end
        if ((r.cnt[i] + 8'h01) >= r.div[i]) begin
          n.cnt[i] = 8'h00;
          n.clk_o[i] = ~r.clk_o[i];
          otick[i] = 1'b1;
        end else begin
          n.cnt[i] = r.cnt[i] + 8'h01;
        end
      end
    end

    // dynamic phase port; set wins over the pending clear above
    step_edge = link.phase_shift_pulse != r.step_prev;
    n.step_prev = link.phase_shift_pulse;
    tgt = link.phase_target_select + fpc_pkg::SEL_TO_CH;
    if (step_edge) begin
      if (link.phase_shift_direction) begin
        n.adv[tgt] = 1'b1;
      end else begin
        n.dly[tgt] = 1'b1;
      end
    end

    // configuration port: ack one cycle after the strobe
    take = link.wb_cyc & link.wb_stb & ~r.ack;
    n.ack = take;
    if (take && link.wb_we) begin
      if (link.wb_adr == fpc_pkg::A_MULT) begin
        n.mult = (link.wb_dat_w < fpc_pkg::MULT_MIN) ? fpc_pkg::MULT_MIN : link.wb_dat_w;
      end else if (link.wb_adr == fpc_pkg::A_FRAC_LO) begin
        n.frac[7:0] = link.wb_dat_w;
      end else if (link.wb_adr == fpc_pkg::A_FRAC_HI) begin
        n.frac[15:8] = link.wb_dat_w;
      end else if (link.wb_adr == fpc_pkg::A_CASCADE) begin
        n.cascade = link.wb_dat_w[3:0];
      end else if (link.wb_adr >= fpc_pkg::A_DIV0 && link.wb_adr <= fpc_pkg::A_DIV3) begin
        n.div[2'(link.wb_adr - fpc_pkg::A_DIV0)] = fpc_pkg::fpc_div_clamp(link.wb_dat_w);
      end else if (link.wb_adr >= fpc_pkg::A_PH1 && link.wb_adr <= fpc_pkg::A_PH3) begin
        // static offset is loaded as the divider count, kept below the divide value
        pv = link.wb_dat_w;
        if (pv >= r.div[2'(link.wb_adr - fpc_pkg::A_PH1) + 2'h1]) begin
          pv = r.div[2'(link.wb_adr - fpc_pkg::A_PH1) + 2'h1] - 8'h01;
        end
        n.phase[2'(link.wb_adr - fpc_pkg::A_PH1)] = pv;
        n.cnt[2'(link.wb_adr - fpc_pkg::A_PH1) + 2'h1] = pv;
      end else if (link.wb_adr == fpc_pkg::A_CTRL) begin
        n.fb_ext = link.wb_dat_w[fpc_pkg::B_FB_EXT];
      end
    end
    // read mux; unmapped addresses read zero
    n.rdata = 8'h00;
    if (take && !link.wb_we) begin
      case (link.wb_adr)
        fpc_pkg::A_MULT: n.rdata = r.mult;
        fpc_pkg::A_FRAC_LO: n.rdata = r.frac[7:0];
        fpc_pkg::A_FRAC_HI: n.rdata = r.frac[15:8];
        fpc_pkg::A_CASCADE: n.rdata = {4'h0, r.cascade};
        4'h4, 4'h5, 4'h6, 4'h7: n.rdata = r.div[2'(link.wb_adr - fpc_pkg::A_DIV0)];
        4'h8, 4'h9, 4'hA: n.rdata = r.phase[2'(link.wb_adr - fpc_pkg::A_PH1)];
        fpc_pkg::A_CTRL: n.rdata[fpc_pkg::B_FB_EXT] = r.fb_ext;
        fpc_pkg::A_STATUS: begin
          n.rdata[fpc_pkg::B_LOCK] = r.lock;
          n.rdata[fpc_pkg::B_REF_SEL] = r.ref_sel;
        end
        default: n.rdata = 8'h00;
      endcase
    end

    // lock: dropped by any write but to status, a reference switch, a primary phase step or missing feedback
    upset = (take && link.wb_we && link.wb_adr != fpc_pkg::A_STATUS)
          || (link.reference_source_switch != r.ref_sel)
          || (step_edge && tgt == fpc_pkg::CH_PRIMARY);
    lost = (r.watch >= FB_TMO);
    if (fb_edge) begin
      n.watch = 16'h0000;
    end else if (!lost) begin
      n.watch = r.watch + 16'h0001;
    end
    if (upset || lost) begin
      n.lock = 1'b0;
      n.acq = 16'h0000;
    end else if (r.acq < fpc_pkg::ACQ_CNT) begin
      n.acq = r.acq + 16'h0001;
    end else begin
      n.lock = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.mult <= fpc_pkg::R_MULT;
      r.frac <= fpc_pkg::R_FRAC;
      r.div <= {fpc_pkg::CH_N{fpc_pkg::R_DIV}};
      r.phase <= {3{fpc_pkg::R_PHASE}};
    end else begin
      r <= n;
    end
  end

  // outputs are plain flops, fit for global or general routing
  assign primary_clock_out = r.clk_o[0];
  assign first_aux_clock_out = r.clk_o[1];
  assign second_aux_clock_out = r.clk_o[2];
  assign third_aux_clock_out = r.clk_o[3];
  assign link.lock = r.lock;
  assign link.wb_ack = r.ack;
  assign link.wb_dat_r = r.rdata;
endmodule
`default_nettype wire

// file: src/fpc_user_end.sv
// Purpose: user logic end that configures, steps and watches the synthesiser
// Assumes: device answers each configuration access with a one-cycle ack
// Notes: clock_trusted waits out the acquisition time after every disturbance
`default_nettype none
module fpc_user_end (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [3:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic cfg_busy,
  output logic cfg_done,
  output logic [7:0] cfg_rdata,
  input wire logic step_req,
  input wire logic [1:0] step_sel,
  input wire logic step_dir,
  input wire logic ref_choice,
  output logic clock_trusted,
  fpc_link_if.usr link
);
  typedef struct packed {
    fpc_pkg::fpc_host_st_type st;
    logic cyc;
    logic we;
    logic [3:0] adr;
    logic [7:0] wdat;
    logic busy;
    logic done;
    logic [7:0] rdata;
    logic pulse;
    logic [1:0] sel;
    logic dir;
    logic refsw;
    logic [15:0] wait_cnt;
    logic trusted;
  } fpc_host_type;

  fpc_host_type r;
  fpc_host_type n;
  logic upset;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    upset = 1'b0;
    n.done = 1'b0;
    case (r.st)
      fpc_pkg::FPC_IDLE: begin
        if (cfg_req) begin
          n.cyc = 1'b1;
          n.we = cfg_we;
          n.adr = cfg_addr;
          n.wdat = cfg_wdata;
          n.busy = 1'b1;
          n.st = fpc_pkg::FPC_BUS;
        end
      end
      fpc_pkg::FPC_BUS: begin
        if (link.wb_ack) begin
          n.cyc = 1'b0;
          n.busy = 1'b0;
          n.done = 1'b1;
          n.rdata = link.wb_dat_r;
          n.st = fpc_pkg::FPC_IDLE;
          upset = r.we;
        end
      end
      default: begin
        n.st = fpc_pkg::FPC_IDLE;
        n.cyc = 1'b0;
        n.busy = 1'b0;
      end
    endcase
    // each request is one toggle, so back-to-back steps stay distinct
    if (step_req) begin
      n.pulse = ~r.pulse;
      n.sel = step_sel;
      n.dir = step_dir;
      if ((step_sel + fpc_pkg::SEL_TO_CH) == fpc_pkg::CH_PRIMARY) begin
        upset = 1'b1;
      end
    end
    if (ref_choice != r.refsw) begin
      n.refsw = ref_choice;
      upset = 1'b1;
    end
    // trust only after the full wait and with the lock indicator up
    if (upset) begin
      n.wait_cnt = '0;
      n.trusted = 1'b0;
    end else if (r.wait_cnt < fpc_pkg::ACQ_CNT) begin
      n.wait_cnt = r.wait_cnt + 16'h0001;
      n.trusted = 1'b0;
    end else begin
      n.trusted = link.lock;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= '{st: fpc_pkg::FPC_IDLE, adr: 4'h0, wdat: 8'h00, rdata: 8'h00,
             sel: 2'h0, wait_cnt: 16'h0000, default: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign link.wb_cyc = r.cyc;
  assign link.wb_stb = r.cyc;
  assign link.wb_we = r.we;
  assign link.wb_adr = r.adr;
  assign link.wb_dat_w = r.wdat;
  assign link.phase_target_select = r.sel;
  assign link.phase_shift_direction = r.dir;
  assign link.phase_shift_pulse = r.pulse;
  assign link.reference_source_switch = r.refsw;
  assign cfg_busy = r.busy;
  assign cfg_done = r.done;
  assign cfg_rdata = r.rdata;
  assign clock_trusted = r.trusted;
endmodule
`default_nettype wire

// file: tb/fpc_link_monitor.sv
// Purpose: watch the link between the user end and the synthesiser
// Assumes: one mclk domain, rst asynchronous and active high
// Notes: the lock hold-off counter saturates instead of wrapping
`default_nettype none
module fpc_link_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [3:0] wb_adr,
  input wire logic [7:0] wb_dat_r,
  input wire logic wb_ack,
  input wire logic [1:0] phase_target_select,
  input wire logic phase_shift_pulse,
  input wire logic reference_source_switch,
  input wire logic lock
);
  logic [15:0] low_r;
  // ----------------------------------------------------------------
  // lock hold-off counter and properties
  // ----------------------------------------------------------------
  // cycles lock was seen low; saturating so a long outage never looks short
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_r <= 16'h0000;
    end else if (lock) begin
      low_r <= 16'h0000;
    end else if (low_r != 16'hFFFF) begin
      low_r <= low_r + 16'h0001;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  chk_take_gets_ack: assert property ($rose(wb_cyc && wb_stb) |=> wb_ack)
    else $error("no ack one cycle after a take");
  chk_ack_one_cycle: assert property (wb_ack |=> !wb_ack)
    else $error("ack stood longer than one cycle");
  chk_ack_in_cycle: assert property (wb_ack |-> wb_cyc && wb_stb)
    else $error("ack outside a bus cycle");
  chk_cyc_held: assert property (wb_cyc && !wb_ack |=> wb_cyc && wb_stb)
    else $error("bus cycle dropped before ack");
  chk_cyc_release: assert property (wb_ack |=> !wb_cyc)
    else $error("bus cycle kept after ack");
  chk_write_data_zero: assert property (wb_ack && wb_we |-> wb_dat_r == 8'h00)
    else $error("read data not zero on a write");
  chk_write_drops_lock: assert property (
    wb_ack && wb_we && wb_adr != fpc_pkg::A_STATUS |=> !lock)
    else $error("lock kept after a settings write");
  chk_ref_drops_lock: assert property ($changed(reference_source_switch) |=> !lock)
    else $error("lock kept after reference switch");
  chk_primary_step: assert property (
    $changed(phase_shift_pulse) && phase_target_select == 2'h3 |=> !lock)
    else $error("lock kept after primary phase step");
  chk_lock_holdoff: assert property (
    $rose(lock) |-> low_r >= fpc_pkg::ACQ_CNT - 16'h0001)
    else $error("lock rose before acquisition time");
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: drive both ends of the synthesiser link and check results
// Assumes: synthesiser built with a short feedback timeout
// Notes: frequency checks allow slack for counts cut at window edges
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, cfg_req, cfg_we, cfg_busy, cfg_done, step_req, step_dir;
  logic ref_choice, clock_trusted, ref_a, ref_b, fb_pin, fb_en;
  logic [3:0] cfg_addr;
  logic [7:0] cfg_wdata, cfg_rdata;
  logic [1:0] step_sel;
  logic [15:0] div_r, frac;
  logic [3:0] pv;
  logic [23:0] tab[11];
  logic [7:0] exp_q[$];
  wire logic [3:0] clk_o;
  int num_errors, samples_checked, tg[4], d[4], ra, rb, da, db;
  fpc_link_if lnk();
  fpc_synth_end #(.FB_TIMEOUT_US(20)) fpc_synth_end_inst (
    .mclk(mclk), .rst(rst), .reference_clock_in(ref_a), .reference_clock_alt(ref_b),
    .feedback_clock_in(fb_pin), .primary_clock_out(clk_o[0]), .first_aux_clock_out(clk_o[1]),
    .second_aux_clock_out(clk_o[2]), .third_aux_clock_out(clk_o[3]), .link(lnk.dev));
  fpc_user_end fpc_user_end_inst (
    .mclk(mclk), .rst(rst), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_busy(cfg_busy), .cfg_done(cfg_done), .cfg_rdata(cfg_rdata),
    .step_req(step_req), .step_sel(step_sel), .step_dir(step_dir), .ref_choice(ref_choice),
    .clock_trusted(clock_trusted), .link(lnk.usr));
  fpc_link_monitor fpc_link_monitor_inst (
    .mclk(mclk), .rst(rst), .wb_cyc(lnk.wb_cyc), .wb_stb(lnk.wb_stb), .wb_we(lnk.wb_we),
    .wb_adr(lnk.wb_adr), .wb_dat_r(lnk.wb_dat_r), .wb_ack(lnk.wb_ack),
    .phase_target_select(lnk.phase_target_select), .phase_shift_pulse(lnk.phase_shift_pulse),
    .reference_source_switch(lnk.reference_source_switch), .lock(lnk.lock));
  // ----------------------------------------------------------------
  // clock, pins and watchers
  // ----------------------------------------------------------------
  // 10 MHz system clock
  always #50 mclk = ~mclk;
  // reference pins and toggle counts share one process so their edges never race
  always @(negedge mclk) begin
    for (int i = 0; i < 4; i++) if (clk_o[i] !== pv[i]) tg[i]++;
    pv = clk_o;
    div_r = div_r + 16'h0001;
    if (!ref_a && div_r[4]) ra++;
    if (!ref_b && div_r[5]) rb++;
    ref_a = div_r[4];
    ref_b = div_r[5];
    fb_pin = fb_en & div_r[4];
  end
  // every finished access is compared with the oldest queued note
  always @(negedge mclk) begin
    if (cfg_done === 1'b1) begin
      if (exp_q.size() == 0) chk("cfg_done", 32'h0, 32'h1, 0);
      else chk("cfg_rdata", 32'(exp_q.pop_front()), 32'(cfg_rdata), 0);
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g, input int t);
    samples_checked++;
    if ((t == 0) ? (g !== e) : (g + t < e || g > e + t)) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic test_done();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic fail();
    num_errors++;
    $display("ERROR wait expected handshake seen timeout");
    test_done();
  endtask
  // one access through the user end; request held low again once taken
  task automatic acc(input logic we, input logic [3:0] a, input logic [7:0] w,
                     input logic [7:0] e);
    int n;
    exp_q.push_back(e);
    @(negedge mclk);
    {cfg_we, cfg_addr, cfg_wdata, cfg_req} = {we, a, w, 1'b1};
    @(negedge mclk);
    cfg_req = 1'b0;
    n = 0;
    while (cfg_done !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    if (n == 20) fail();
  endtask
  // wait for the user end to trust its clocks again
  task automatic wt();
    int n;
    n = 0;
    while (clock_trusted !== 1'b1 && n < 4000) begin
      @(negedge mclk);
      n++;
    end
    if (n == 4000) fail();
    chk("lock", 32'h1, 32'(lnk.lock), 0);
  endtask
  task automatic meas(input int n);
    int s[4];
    int sa;
    int sb;
    s = tg;
    sa = ra;
    sb = rb;
    repeat (n) @(negedge mclk);
    for (int i = 0; i < 4; i++) d[i] = tg[i] - s[i];
    da = ra - sa;
    db = rb - sb;
  endtask
  // primary toggles with divider 1: one per oscillator tick
  function automatic int fexp(input int e);
    return (e * (65536 * int'(fpc_pkg::R_MULT) + int'(frac))) / 65536;
  endfunction
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {mclk, cfg_req, cfg_we, cfg_addr, cfg_wdata, step_req, step_sel, step_dir} = '0;
    {ref_choice, ref_a, ref_b, fb_pin, fb_en, div_r, frac} = '0;
    rst = 1'b1;
    tab = '{24'h140000, 24'h040001, 24'h17FF00, 24'h070080, 24'h150200, 24'h160200,
            24'h170300, 24'h18FF00, 24'h080001, 24'h130800, 24'h030008};
    void'($urandom(1946));
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    for (int a = 0; a < 16; a++) begin
      acc(1'b0, 4'(a), 8'h00, (a == 0 || (a > 3 && a < 8)) ? 8'h04 : 8'h00);
    end
    wt();
    acc(1'b1, fpc_pkg::A_STATUS, 8'hFF, 8'h00);
    acc(1'b0, fpc_pkg::A_STATUS, 8'h00, 8'h01);
    // clamping at both divider limits, phase clamp, then a cascaded chain
    foreach (tab[i]) acc(tab[i][20], tab[i][19:16], tab[i][15:8], tab[i][7:0]);
    frac = 16'($urandom);
    acc(1'b1, fpc_pkg::A_FRAC_LO, frac[7:0], 8'h00);
    acc(1'b1, fpc_pkg::A_FRAC_HI, frac[15:8], 8'h00);
    acc(1'b0, fpc_pkg::A_FRAC_LO, 8'h00, frac[7:0]);
    chk("clock_trusted", 32'h0, 32'(clock_trusted), 0);
    wt();
    meas(4000);
    chk("primary", fexp(da), d[0], 8);
    chk("first aux", d[0] / 2, d[1], 4);
    chk("second aux", d[0] / 2, d[2], 4);
    chk("third aux", d[2] / 3, d[3], 3);
    for (int c = 0; c < 4; c++) begin
      @(negedge mclk);
      {step_sel, step_dir, step_req} = {2'(c), 1'($urandom), 1'b1};
      @(negedge mclk);
      step_req = 1'b0;
      repeat (4) @(negedge mclk);
      chk("lock after step", (c == 3) ? 32'h0 : 32'h1, 32'(lnk.lock), 0);
    end
    wt();
    ref_choice = 1'b1;
    repeat (4) @(negedge mclk);
    chk("lock after switch", 32'h0, 32'(lnk.lock), 0);
    wt();
    acc(1'b0, fpc_pkg::A_STATUS, 8'h00, 8'h03);
    meas(4000);
    chk("primary on alt", fexp(db), d[0], 8);
    ref_choice = 1'b0;
    fb_en = 1'b1;
    acc(1'b1, fpc_pkg::A_CTRL, 8'h01, 8'h00);
    wt();
    // starving the external feedback pin must be seen as loss of lock
    fb_en = 1'b0;
    repeat (400) @(negedge mclk);
    chk("lock without feedback", 32'h0, 32'(lnk.lock), 0);
    fb_en = 1'b1;
    wt();
    test_done();
  end
endmodule
`default_nettype wire
